// ---- fdp_fault_detect.sv ----
`timescale 1ns/1ps
`include "fdp_regs.svh"
module fdp_fault_detect import fdp_pkg::*; (
  // Clock and reset pairs.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic rst_red_n_i,
  input wire logic fmu_rst_n_i,
  input wire logic fmu_rst_red_n_i,
  input wire logic mtest_rst_n_i,
  input wire logic mtest_rst_red_n_i,
  output logic mtest_rst_o,
  // Scan controls.
  input wire logic scan_rst_dis_i,
  input wire logic scan_rst_dis_red_i,
  input wire logic scan_cg_force_red_i,
  output logic red_cg_en_o,
  // Functional datapath under lock-step.
  input wire logic func_en_i,
  input wire logic [7:0] func_data_i,
  output logic [7:0] func_data_o,
  // Shared RAM port.
  input wire logic ram_we_i,
  input wire logic ram_re_i,
  input wire logic [3:0] ram_addr_i,
  input wire logic [7:0] ram_wdata_i,
  output logic [7:0] ram_rdata_o,
  // Watchdog and buffer unit fault wires.
  output logic [`FDP_BUF_UNITS-1:0] ping_o,
  input wire logic [`FDP_BUF_UNITS-1:0] ping_ack_i,
  input wire logic [`FDP_BUF_WIRES-1:0] buf_fault_i,
  // Fault indicator channels.
  input wire logic [`FDP_CHANNELS-1:0] fault_req_i,
  input wire logic [`FDP_CHANNELS-1:0] fault_req_red_i,
  output logic [`FDP_CHANNELS-1:0] fault_ack_o,
  output logic [`FDP_CHANNELS-1:0] fault_ack_red_o,
  // Configuration tie-offs and their inverted copies.
  input wire logic [`FDP_TIES-1:0] cfg_tie_i,
  input wire logic [`FDP_TIES-1:0] cfg_tie_red_i,
  // Dedicated APB port of the fault unit.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pwdata_chk_i,
  output logic [31:0] prdata_o,
  output logic prdata_chk_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupts to the safety island.
  output logic fault_handling_irq_o,
  output logic fault_handling_irq_chk_o,
  output logic error_recovery_irq_o,
  output logic error_recovery_irq_chk_o
);
  localparam int NB = `FDP_BUF_UNITS;
  localparam int NC = `FDP_CHANNELS;
  localparam int NT = `FDP_TIES;
  localparam int SW = NB + `FDP_BUF_WIRES + 2 * NC + 2 * NT + 2;

  // CRC over address and data; used on write and on read check.
  function automatic logic [7:0] fdp_crc8(input logic [11:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 11; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `FDP_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : fdp_crc8

  // Mapped-address test, used only by the error answer; read data decodes its own offsets.
  function automatic logic fdp_hit(input logic [7:0] a);
    return a == `FDP_OFS_STATUS || a == `FDP_OFS_INJECT || a == `FDP_OFS_FHI_EN ||
      a == `FDP_OFS_ERI_EN || a == `FDP_OFS_WD_TMO || a == `FDP_OFS_SYND;
  endfunction : fdp_hit

  // Reset generators; the redundant chains are two stages longer.
  logic [1:0] prst; // Primary main reset chain.
  logic [3:0] rrst; // Redundant main reset chain.
  logic [1:0] frst; // Primary fault-unit reset chain.
  logic [3:0] frrst; // Redundant fault-unit reset chain.
  wire main_rst = ~prst[1];
  wire red_rst = ~rrst[3];
  wire fmu_rst = ~frst[1] | ~frrst[3];

  // Scan disable holds the chains released so scanned flops stay quiet.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i && !scan_rst_dis_i) prst <= 2'h0;
    else prst <= {prst[0], 1'b1};
    if (!fmu_rst_n_i && !scan_rst_dis_i) frst <= 2'h0;
    else frst <= {frst[0], 1'b1};
  end

  // Redundant chains release two cycles after the primary ones.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_red_n_i && !scan_rst_dis_red_i) rrst <= 4'h0;
    else rrst <= {rrst[2:0], 1'b1};
    if (!fmu_rst_red_n_i && !scan_rst_dis_red_i) frrst <= 4'h0;
    else frrst <= {frrst[2:0], 1'b1};
  end

  // Two-flop synchroniser for every pin from outside this domain.
  // Left without reset: a reset value of zero would fake a tie-off fault.
  logic [SW-1:0] sync1; // First stage; read only by the second.
  logic [SW-1:0] sync2; // Second stage; safe to use.
  always_ff @(posedge sys_clk_i) begin
    sync1 <= {ping_ack_i, buf_fault_i, fault_req_i, fault_req_red_i, cfg_tie_i, cfg_tie_red_i,
      mtest_rst_n_i, mtest_rst_red_n_i};
    sync2 <= sync1;
  end
  wire mtest_red_s = sync2[0];
  wire mtest_s = sync2[1];
  wire [NT-1:0] tie_red_s = sync2[2+:NT];
  wire [NT-1:0] tie_s = sync2[2+NT+:NT];
  wire [NC-1:0] req_red_s = sync2[2+2*NT+:NC];
  wire [NC-1:0] req_s = sync2[2+2*NT+NC+:NC];
  wire [`FDP_BUF_WIRES-1:0] bfault_s = sync2[2+2*NT+2*NC+:`FDP_BUF_WIRES];
  wire [NB-1:0] ack_s = sync2[SW-NB+:NB];

  // Memory-test reset only takes effect when both copies assert.
  always_ff @(posedge sys_clk_i) begin
    if (main_rst) mtest_rst_o <= 1'b0;
    else mtest_rst_o <= ~mtest_s & ~mtest_red_s;
  end

  // Input delay line feeding the redundant copy.
  logic [1:0] d_en; // Enables delayed by one and two cycles.
  logic [7:0] d_dat [2]; // Data delayed by one and two cycles.
  logic [7:0] p_acc; // Primary functional state.
  logic [7:0] p_dly [2]; // Primary result aligned to the redundant copy.
  logic [7:0] r_acc; // Redundant functional state.
  always_ff @(posedge sys_clk_i) begin
    if (main_rst) begin
      d_en <= 2'h0;
      p_acc <= 8'h00;
    end else begin
      d_en <= {d_en[0], func_en_i};
      if (func_en_i) p_acc <= p_acc + func_data_i;
    end
    d_dat[0] <= func_data_i;
    d_dat[1] <= d_dat[0];
    p_dly[0] <= p_acc;
    p_dly[1] <= p_dly[0];
  end

  // The redundant copy runs on its own late-released reset.
  always_ff @(posedge sys_clk_i) begin
    if (red_rst) r_acc <= 8'h00;
    else if (d_en[1]) r_acc <= r_acc + d_dat[1];
  end
  assign func_data_o = p_acc;
  wire ls_err = ~red_rst & (p_dly[1] != r_acc);
  // Force keeps redundant gates open during scan.
  assign red_cg_en_o = d_en[1] | scan_cg_force_red_i;

  // Shared RAM: each entry holds the CRC beside its data.
  logic [15:0] mem [16]; // CRC in [15:8], data in [7:0].
  logic [15:0] rd_q; // Registered read entry.
  logic [3:0] rd_addr_q; // Address of the registered read.
  logic rd_vld_q; // A read completed last cycle.
  logic [7:0] inject; // Per-mechanism fault injection.
  wire [7:0] wr_crc = fdp_crc8({ram_addr_i, ram_wdata_i}) ^ {7'h00, inject[FDP_SM_CRC]};
  always_ff @(posedge sys_clk_i) begin
    if (ram_we_i) mem[ram_addr_i] <= {wr_crc, ram_wdata_i};
    rd_q <= mem[ram_addr_i];
    rd_addr_q <= ram_addr_i;
    if (main_rst) rd_vld_q <= 1'b0;
    else rd_vld_q <= ram_re_i;
  end
  assign ram_rdata_o = rd_q[7:0];
  wire crc_err = rd_vld_q & (rd_q[15:8] != fdp_crc8({rd_addr_q, rd_q[7:0]}));

  // Watchdog: ping one buffer unit, wait for its answer, then move on.
  fdp_wd_t wd_st; // Sequencer state.
  logic [1:0] wd_idx; // Buffer unit under test.
  logic [15:0] wd_cnt; // Cycles waited so far.
  logic [15:0] wd_tmo; // Programmed timeout.
  logic [NB-1:0] ping; // Ping lines.
  wire ack_sel = ack_s[wd_idx];
  wire [NB-1:0] ping_sel = NB'(1) << wd_idx;
  wire wd_err = (wd_st == FDP_WD_WAIT) & ~ack_sel & (wd_cnt == wd_tmo);
  always_ff @(posedge sys_clk_i) begin
    if (main_rst) begin
      wd_st <= FDP_WD_PING;
      wd_idx <= 2'h0;
      wd_cnt <= 16'h0000;
      ping <= '0;
    end else begin
      unique case (wd_st)
        FDP_WD_PING: begin
          ping <= ping_sel;
          wd_cnt <= 16'h0000;
          wd_st <= FDP_WD_WAIT;
        end
        FDP_WD_WAIT: begin
          wd_cnt <= wd_cnt + 16'h0001;
          // An answer or a timeout both end the wait.
          if (ack_sel || wd_err) begin
            ping <= '0;
            wd_st <= FDP_WD_NEXT;
          end
        end
        FDP_WD_NEXT: begin
          // Let the answer drop before pinging the next unit.
          if (!ack_sel) begin
            wd_idx <= wd_idx + 2'h1;
            wd_st <= FDP_WD_PING;
          end
        end
        default: wd_st <= FDP_WD_PING;
      endcase
    end
  end
  assign ping_o = ping;

  // Fault indicator channels: acknowledge follows the captured request.
  logic [NC-1:0] ack; // Acknowledge flops, one per channel.
  genvar g;
  for (g = 0; g < NC; g++) begin : g_chan
    always_ff @(posedge sys_clk_i) begin
      if (main_rst) ack[g] <= 1'b0;
      else ack[g] <= req_s[g];
    end
  end
  assign fault_ack_o = ack;
  assign fault_ack_red_o = ack;
  // A new request or a split between the copies is a fault.
  wire ch_err = |(req_s & ~ack) | |(req_s ^ req_red_s);
  wire tie_err = |(tie_s ~^ tie_red_s);
  wire buf_err = |bfault_s;
  wire mtest_err = mtest_s ^ mtest_red_s;

  // APB slave; always ready, error on unmapped offsets.
  wire apb_acc = psel_i & penable_i;
  wire apb_wr = apb_acc & pwrite_i;
  wire par_err = apb_wr & ~(^{pwdata_i, pwdata_chk_i});
  wire st_wr = apb_wr & (paddr_i == `FDP_OFS_STATUS);
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc & ~fdp_hit(paddr_i);

  // Detected faults, with injection forcing any mechanism.
  wire [7:0] det = {mtest_err, par_err, tie_err, ch_err, buf_err, wd_err, crc_err, ls_err} | inject;

  logic [7:0] rec; // Sticky error record.
  logic [7:0] synd; // Syndrome of the first recorded fault.
  logic [7:0] fhi_en; // Mask onto the fault-handling interrupt.
  logic [7:0] eri_en; // Mask onto the error-recovery interrupt.
  wire [7:0] clr = st_wr ? pwdata_i[7:0] : 8'h00;
  wire [7:0] next_rec = (rec & ~clr) | det;
  wire next_fhi = |(next_rec & fhi_en);
  wire next_eri = |(next_rec & eri_en);

  // Fault unit registers live only on the fault-unit reset.
  always_ff @(posedge sys_clk_i) begin
    if (fmu_rst) begin
      rec <= 8'h00;
      synd <= 8'h00;
      inject <= 8'h00;
      fhi_en <= `FDP_RST_MASK;
      eri_en <= `FDP_RST_MASK;
      wd_tmo <= `FDP_RST_WD_TMO;
    end else begin
      // Setting wins over a clear in the same cycle.
      rec <= next_rec;
      if (rec == 8'h00 && det != 8'h00) synd <= det;
      if (apb_wr && paddr_i == `FDP_OFS_INJECT) inject <= pwdata_i[7:0];
      if (apb_wr && paddr_i == `FDP_OFS_FHI_EN) fhi_en <= pwdata_i[7:0];
      if (apb_wr && paddr_i == `FDP_OFS_ERI_EN) eri_en <= pwdata_i[7:0];
      if (apb_wr && paddr_i == `FDP_OFS_WD_TMO) wd_tmo <= pwdata_i[15:0];
    end
  end

  // Interrupts and their inverted check bits, both from flops.
  always_ff @(posedge sys_clk_i) begin
    if (fmu_rst) begin
      fault_handling_irq_o <= 1'b0;
      fault_handling_irq_chk_o <= 1'b1;
      error_recovery_irq_o <= 1'b0;
      error_recovery_irq_chk_o <= 1'b1;
    end else begin
      fault_handling_irq_o <= next_fhi;
      fault_handling_irq_chk_o <= ~next_fhi;
      error_recovery_irq_o <= next_eri;
      error_recovery_irq_chk_o <= ~next_eri;
    end
  end

  // Read data is captured in the setup phase so it stands in access.
  wire [31:0] rd_mux = (paddr_i == `FDP_OFS_STATUS) ? {24'h000000, rec} :
    (paddr_i == `FDP_OFS_INJECT) ? {24'h000000, inject} :
    (paddr_i == `FDP_OFS_FHI_EN) ? {24'h000000, fhi_en} :
    (paddr_i == `FDP_OFS_ERI_EN) ? {24'h000000, eri_en} :
    (paddr_i == `FDP_OFS_WD_TMO) ? {16'h0000, wd_tmo} :
    (paddr_i == `FDP_OFS_SYND) ? {24'h000000, synd} : 32'h00000000;
  always_ff @(posedge sys_clk_i) begin
    if (fmu_rst) begin
      prdata_o <= 32'h00000000;
      prdata_chk_o <= 1'b1;
    end else if (psel_i && !penable_i) begin
      prdata_o <= rd_mux;
      prdata_chk_o <= ~(^rd_mux);
    end
  end

  // Checks on the safety logic.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (fmu_rst);

  ls_cmp_a: assert property ((!red_rst && p_dly[1] != r_acc) |=> rec[FDP_SM_LOCKSTEP])
    else $error("lock-step mismatch not recorded");
  red_rst_lag_a: assert property (($rose(rrst[1]) && rst_red_n_i ##1 rst_red_n_i) |=> rrst[3])
    else $error("redundant reset release not two cycles later");
  crc_chk_a: assert property (crc_err |=> rec[FDP_SM_CRC])
    else $error("crc error not recorded");
  irq_par_a: assert property (!fmu_rst |-> (fault_handling_irq_o != fault_handling_irq_chk_o) &&
    (error_recovery_irq_o != error_recovery_irq_chk_o))
    else $error("interrupt check bit wrong");
  wd_tmo_a: assert property ((wd_st == FDP_WD_WAIT && wd_cnt == wd_tmo && !ack_sel) |=>
    (rec[FDP_SM_WATCHDOG] && wd_st == FDP_WD_NEXT && ping_o == '0))
    else $error("watchdog timeout not reported");
  wd_rr_a: assert property ((!main_rst && wd_st == FDP_WD_NEXT && !ack_sel) ##1 !main_rst |->
    ##1 (ping_o == (NB'(1) << wd_idx)) && wd_idx == 2'($past(wd_idx, 2) + 2'h1))
    else $error("watchdog did not advance round-robin");
  fhi_a: assert property (!fmu_rst |-> fault_handling_irq_o == (|(rec & $past(fhi_en))))
    else $error("fault handling interrupt wrong");
  eri_a: assert property (!fmu_rst |-> error_recovery_irq_o == (|(rec & $past(eri_en))))
    else $error("error recovery interrupt wrong");
  rec_keep_a: assert property (!st_wr |=> (rec & $past(rec)) == $past(rec))
    else $error("error record lost without fault reset");
  chan_ack_a: assert property ((!main_rst && req_s[0]) ##1 !main_rst |-> fault_ack_o[0])
    else $error("fault channel not acknowledged");
  tie_chk_a: assert property (tie_err |=> rec[FDP_SM_TIEOFF])
    else $error("tie-off fault not recorded");
endmodule : fdp_fault_detect

// ---- fdp_regs.svh ----
`ifndef FDP_REGS_SVH
`define FDP_REGS_SVH
// Fault unit register offsets on the dedicated APB port.
`define FDP_OFS_STATUS 8'h00
`define FDP_OFS_INJECT 8'h04
`define FDP_OFS_FHI_EN 8'h08
`define FDP_OFS_ERI_EN 8'h0C
`define FDP_OFS_WD_TMO 8'h10
`define FDP_OFS_SYND 8'h14
// Reset values.
`define FDP_RST_MASK 8'hFF
`define FDP_RST_WD_TMO 16'h0100
// Sizes of the configurable buses.
`define FDP_BUF_UNITS 4
`define FDP_BUF_WIRES 4
`define FDP_CHANNELS 2
`define FDP_TIES 4
// CRC generator polynomial for shared RAM entries.
`define FDP_CRC_POLY 8'h07
`endif

// ---- fdp_pkg.sv ----
package fdp_pkg;
  // Watchdog sequencer states.
  typedef enum logic [1:0] {
    FDP_WD_PING = 2'b00,
    FDP_WD_WAIT = 2'b01,
    FDP_WD_NEXT = 2'b10
  } fdp_wd_t;
  // Bit position of each safety mechanism in the error record.
  typedef enum logic [2:0] {
    FDP_SM_LOCKSTEP = 3'h0,
    FDP_SM_CRC = 3'h1,
    FDP_SM_WATCHDOG = 3'h2,
    FDP_SM_BUF_WIRE = 3'h3,
    FDP_SM_CHANNEL = 3'h4,
    FDP_SM_TIEOFF = 3'h5,
    FDP_SM_BUS_PAR = 3'h6,
    FDP_SM_MTEST = 3'h7
  } fdp_sm_t;
endpackage : fdp_pkg

// ---- fdp_buf_model.sv ----
`timescale 1ns/1ps
`include "fdp_regs.svh"
// Buffer units on the far side: they answer watchdog pings and drive fault wires.
module fdp_buf_model (
  // Clock.
  input wire logic sys_clk_i,
  // Watchdog handshake.
  input wire logic [`FDP_BUF_UNITS-1:0] ping_i,
  input wire logic [`FDP_BUF_UNITS-1:0] mute_i,
  input wire logic [3:0] lat_i,
  output logic [`FDP_BUF_UNITS-1:0] ping_ack_o,
  // Fault wires.
  input wire logic [`FDP_BUF_WIRES-1:0] fault_i,
  output logic [`FDP_BUF_WIRES-1:0] buf_fault_o
);
  // Wait counters per unit; a slow unit answers late, a muted unit never does.
  logic [3:0] wait_cnt [`FDP_BUF_UNITS];
  initial ping_ack_o = '0;
  // The answer stays up until the ping drops, so the watchdog sees a full handshake from every unit that is not muted.
  always @(posedge sys_clk_i) begin
    for (int i = 0; i < `FDP_BUF_UNITS; i++) begin
      if (!ping_i[i]) begin
        wait_cnt[i] <= 4'h0;
        ping_ack_o[i] <= 1'b0;
      end else if (wait_cnt[i] < lat_i) begin
        wait_cnt[i] <= wait_cnt[i] + 4'h1;
      end else begin
        ping_ack_o[i] <= !mute_i[i];
      end
    end
  end
  // Each unit raises its own wire, one wire per unit.
  assign buf_fault_o = fault_i;
endmodule : fdp_buf_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "fdp_regs.svh"
module tb_top;
  // Stimulus, named after the ports it drives; redundant inputs are driven as copies, the tie-offs as inverted copies.
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0, rst_red_n_i = 1'b0, fmu_rst_n_i = 1'b0, fmu_rst_red_n_i = 1'b0;
  logic mtest_rst_n_i = 1'b1, mtest_rst_red_n_i = 1'b1;
  logic scan_rst_dis_i = 1'b0, scan_rst_dis_red_i = 1'b0, scan_cg_force_red_i = 1'b0;
  logic func_en_i = 1'b0, ram_we_i = 1'b0, ram_re_i = 1'b0;
  logic [7:0] func_data_i = 8'h00, ram_wdata_i = 8'h00, paddr_i = 8'h00;
  logic [3:0] ram_addr_i = 4'h0, cfg_tie_i = 4'hA, cfg_tie_red_i = 4'h5;
  logic [3:0] mute = 4'h0, lat = 4'h3, fault = 4'h0;
  logic [1:0] fault_req_i = 2'h0, fault_req_red_i = 2'h0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pwdata_chk_i = 1'b1;
  logic [31:0] pwdata_i = 32'h0;
  // Design outputs and bench state.
  logic mtest_rst_o, red_cg_en_o, prdata_chk_o, pready_o, pslverr_o, serr;
  logic fault_handling_irq_o, fault_handling_irq_chk_o, error_recovery_irq_o, error_recovery_irq_chk_o;
  logic [7:0] func_data_o, ram_rdata_o;
  logic [3:0] ping_o, ping_ack_i, buf_fault_i, ping_q = 4'h0;
  logic [1:0] fault_ack_o, fault_ack_red_o;
  logic [31:0] prdata_o, rd;
  int n_mismatch = 0;
  int checks_done = 0;
  int order[$];

  fdp_fault_detect dut_u (.sys_clk_i, .rst_n_i, .rst_red_n_i, .fmu_rst_n_i, .fmu_rst_red_n_i,
    .mtest_rst_n_i, .mtest_rst_red_n_i, .mtest_rst_o, .scan_rst_dis_i, .scan_rst_dis_red_i,
    .scan_cg_force_red_i, .red_cg_en_o, .func_en_i, .func_data_i, .func_data_o, .ram_we_i, .ram_re_i,
    .ram_addr_i, .ram_wdata_i, .ram_rdata_o, .ping_o, .ping_ack_i, .buf_fault_i, .fault_req_i,
    .fault_req_red_i, .fault_ack_o, .fault_ack_red_o, .cfg_tie_i, .cfg_tie_red_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pwdata_chk_i, .prdata_o, .prdata_chk_o, .pready_o, .pslverr_o,
    .fault_handling_irq_o, .fault_handling_irq_chk_o, .error_recovery_irq_o, .error_recovery_irq_chk_o);
  fdp_buf_model bm_u (.sys_clk_i, .ping_i(ping_o), .mute_i(mute), .lat_i(lat), .ping_ack_o(ping_ack_i),
    .fault_i(fault), .buf_fault_o(buf_fault_i));

  // Free-running 125 MHz clock.
  initial forever #4 sys_clk_i = ~sys_clk_i;

  // Logs which unit each new ping goes to, so the order can be judged later.
  always @(posedge sys_clk_i) begin
    ping_q <= ping_o;
    for (int i = 0; i < 4; i++) begin
      if (ping_o[i] && !ping_q[i]) order.push_back(i);
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Waits n edges, then a little more so that outputs have settled.
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  // One APB transfer with zero wait states; bad asks for a wrong data check bit.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic bad);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pwdata_chk_i <= ~^d ^ bad;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    rd = prdata_o;
    serr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task rdx(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, e, "read data");
    chk(prdata_chk_o, ~^rd, "read check bit");
  endtask : rdx

  task clr;
    apb(1'b1, `FDP_OFS_STATUS, 32'hFF, 1'b0);
  endtask : clr

  // Each interrupt carries its inverse as the odd-parity check bit.
  task irq(input logic f, input logic e);
    chk(fault_handling_irq_o, f, "handling irq");
    chk(fault_handling_irq_chk_o, !f, "handling check");
    chk(error_recovery_irq_o, e, "recovery irq");
    chk(error_recovery_irq_chk_o, !e, "recovery check");
  endtask : irq

  task rst_pulse(input logic m, input logic f);
    @(posedge sys_clk_i);
    rst_n_i <= !m;
    rst_red_n_i <= !m;
    fmu_rst_n_i <= !f;
    fmu_rst_red_n_i <= !f;
    repeat (2) @(posedge sys_clk_i);
    {rst_n_i, rst_red_n_i, fmu_rst_n_i, fmu_rst_red_n_i} <= 4'hF;
    cyc(6);
  endtask : rst_pulse

  // Reset values of the fault unit and an unmapped access.
  task t_regs;
    rdx(`FDP_OFS_STATUS, 32'h0);
    rdx(`FDP_OFS_FHI_EN, {24'h0, `FDP_RST_MASK});
    rdx(`FDP_OFS_ERI_EN, {24'h0, `FDP_RST_MASK});
    rdx(`FDP_OFS_WD_TMO, {16'h0, `FDP_RST_WD_TMO});
    chk(serr, 1'b0, "mapped error");
    chk(pready_o, 1'b1, "ready");
    apb(1'b0, 8'h40, 32'h0, 1'b0);
    chk(serr, 1'b1, "unmapped error");
    irq(1'b0, 1'b0);
  endtask : t_regs

  // Accumulate three values; the delayed copy must agree and the gate enable must follow.
  task t_lockstep;
    @(posedge sys_clk_i);
    func_en_i <= 1'b1;
    func_data_i <= 8'h11;
    @(posedge sys_clk_i);
    func_data_i <= 8'h22;
    @(posedge sys_clk_i);
    func_data_i <= 8'h33;
    @(posedge sys_clk_i);
    func_en_i <= 1'b0;
    #1;
    chk(red_cg_en_o, 1'b1, "gate on");
    cyc(4);
    chk(func_data_o, 8'h66, "sum");
    chk(red_cg_en_o, 1'b0, "gate off");
    @(posedge sys_clk_i);
    scan_cg_force_red_i <= 1'b1;
    #1;
    chk(red_cg_en_o, 1'b1, "gate forced");
    @(posedge sys_clk_i);
    scan_cg_force_red_i <= 1'b0;
    rdx(`FDP_OFS_STATUS, 32'h0);
  endtask : t_lockstep

  // A written entry reads back clean with no CRC fault.
  task t_ram;
    @(posedge sys_clk_i);
    ram_we_i <= 1'b1;
    ram_addr_i <= 4'h5;
    ram_wdata_i <= 8'hA5;
    @(posedge sys_clk_i);
    ram_we_i <= 1'b0;
    ram_re_i <= 1'b1;
    @(posedge sys_clk_i);
    ram_re_i <= 1'b0;
    #1;
    chk(ram_rdata_o, 8'hA5, "ram data");
    rdx(`FDP_OFS_STATUS, 32'h0);
    // An entry stored while its CRC is corrupted must flag when read back.
    apb(1'b1, `FDP_OFS_INJECT, 32'h2, 1'b0);
    ram_we_i <= 1'b1;
    ram_addr_i <= 4'h6;
    @(posedge sys_clk_i);
    ram_we_i <= 1'b0;
    apb(1'b1, `FDP_OFS_INJECT, 32'h0, 1'b0);
    clr;
    ram_re_i <= 1'b1;
    @(posedge sys_clk_i);
    ram_re_i <= 1'b0;
    rdx(`FDP_OFS_STATUS, 32'h2);
    clr;
  endtask : t_ram

  // Inject and clear every mechanism in turn.
  task t_inject;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `FDP_OFS_INJECT, 32'h1 << i, 1'b0);
      apb(1'b1, `FDP_OFS_INJECT, 32'h0, 1'b0);
      rdx(`FDP_OFS_STATUS, 32'h1 << i);
      rdx(`FDP_OFS_SYND, 32'h1 << i);
      irq(1'b1, 1'b1);
      clr;
      rdx(`FDP_OFS_STATUS, 32'h0);
      irq(1'b0, 1'b0);
    end
  endtask : t_inject

  // Slow units stay inside the window; the order is round-robin; a silent unit times out.
  task t_watchdog;
    apb(1'b1, `FDP_OFS_WD_TMO, 32'h10, 1'b0);
    lat <= 4'h8;
    order.delete();
    for (int n = 0; n < 400 && order.size() < 6; n++) @(posedge sys_clk_i);
    for (int k = 1; k < 6; k++) chk(order[k], (order[0] + k) % 4, "ping order");
    rdx(`FDP_OFS_STATUS, 32'h0);
    mute <= 4'h4;
    cyc(150);
    rdx(`FDP_OFS_STATUS, 32'h4);
    irq(1'b1, 1'b1);
    mute <= 4'h0;
    lat <= 4'h3;
    cyc(60);
    clr;
    rdx(`FDP_OFS_STATUS, 32'h0);
  endtask : t_watchdog

  // Four-phase request on channel 0, then a request whose copy disagrees.
  task t_chan;
    @(posedge sys_clk_i);
    fault_req_i <= 2'h1;
    fault_req_red_i <= 2'h1;
    cyc(2);
    chk(fault_ack_o, 2'h0, "ack early");
    cyc(1);
    chk(fault_ack_o, 2'h1, "ack");
    chk(fault_ack_red_o, 2'h1, "ack copy");
    @(posedge sys_clk_i);
    fault_req_i <= 2'h0;
    fault_req_red_i <= 2'h0;
    cyc(2);
    chk(fault_ack_o, 2'h1, "ack held");
    cyc(1);
    chk(fault_ack_o, 2'h0, "ack dropped");
    rdx(`FDP_OFS_STATUS, 32'h10);
    clr;
    @(posedge sys_clk_i);
    fault_req_red_i <= 2'h2;
    cyc(4);
    fault_req_red_i <= 2'h0;
    rdx(`FDP_OFS_STATUS, 32'h10);
    clr;
  endtask : t_chan

  // Memory-test reset acts only when both inputs are asserted together.
  task t_mtest;
    @(posedge sys_clk_i);
    mtest_rst_n_i <= 1'b0;
    mtest_rst_red_n_i <= 1'b0;
    cyc(2);
    chk(mtest_rst_o, 1'b0, "mtest early");
    cyc(1);
    chk(mtest_rst_o, 1'b1, "mtest on");
    @(posedge sys_clk_i);
    {mtest_rst_n_i, mtest_rst_red_n_i} <= 2'h3;
    cyc(6);
    rdx(`FDP_OFS_STATUS, 32'h0);
    mtest_rst_n_i <= 1'b0;
    cyc(6);
    chk(mtest_rst_o, 1'b0, "mtest single");
    mtest_rst_n_i <= 1'b1;
    rdx(`FDP_OFS_STATUS, 32'h80);
    clr;
  endtask : t_mtest

  // Buffer wire with the handling interrupt masked, then a write with bad parity.
  task t_wire;
    apb(1'b1, `FDP_OFS_FHI_EN, 32'h0, 1'b0);
    fault <= 4'h8;
    @(posedge sys_clk_i);
    fault <= 4'h0;
    cyc(2);
    rdx(`FDP_OFS_STATUS, 32'h8);
    irq(1'b0, 1'b1);
    apb(1'b1, `FDP_OFS_FHI_EN, 32'hFF, 1'b0);
    cyc(2);
    irq(1'b1, 1'b1);
    clr;
    apb(1'b1, `FDP_OFS_FHI_EN, 32'hFF, 1'b1);
    rdx(`FDP_OFS_STATUS, 32'h40);
    clr;
  endtask : t_wire

  // A tie-off fault must survive main resets and fall only to the fault-unit reset.
  task t_resets;
    cfg_tie_red_i <= 4'hA;
    @(posedge sys_clk_i);
    cfg_tie_red_i <= 4'h5;
    cyc(2);
    rdx(`FDP_OFS_STATUS, 32'h20);
    {scan_rst_dis_i, scan_rst_dis_red_i} <= 2'h3;
    rst_pulse(1'b1, 1'b0);
    chk(func_data_o, 8'h66, "scan held");
    {scan_rst_dis_i, scan_rst_dis_red_i} <= 2'h0;
    rst_pulse(1'b1, 1'b0);
    chk(func_data_o, 8'h00, "main reset");
    rdx(`FDP_OFS_STATUS, 32'h20);
    rst_pulse(1'b0, 1'b1);
    rdx(`FDP_OFS_STATUS, 32'h0);
    irq(1'b0, 1'b0);
  endtask : t_resets

  task end_sim;
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    rst_pulse(1'b1, 1'b1);
    t_regs;
    t_lockstep;
    t_ram;
    t_inject;
    t_watchdog;
    t_chan;
    t_mtest;
    t_wire;
    t_resets;
    end_sim;
  end
endmodule : tb_top
